// ### core/opad_pkg.sv
// Shared types and constants for the operand address decoder
package opad_pkg;

  // Operand kinds presented to the decoder
  typedef enum logic [4:0] {
    OPAD_K_NONE    = 5'h00,
    OPAD_K_REG8    = 5'h01,
    OPAD_K_REG16   = 5'h02,
    OPAD_K_REG24   = 5'h03,
    OPAD_K_PUSH    = 5'h04,
    OPAD_K_MEM     = 5'h05,
    OPAD_K_SADDR8  = 5'h06,
    OPAD_K_SADDR16 = 5'h07,
    OPAD_K_SADDR24 = 5'h08,
    OPAD_K_ABS24   = 5'h09,
    OPAD_K_ABS20   = 5'h0a,
    OPAD_K_ABS16   = 5'h0b,
    OPAD_K_ADDR11  = 5'h0c,
    OPAD_K_ADDR8   = 5'h0d,
    OPAD_K_ADDR5   = 5'h0e,
    OPAD_K_RELOC   = 5'h0f,
    OPAD_K_IMM     = 5'h10
  } opad_kind_t;

  // Memory operand forms
  typedef enum logic [4:0] {
    OPAD_M_IND_P6 = 5'h00, OPAD_M_IND_P7 = 5'h01,
    OPAD_M_IND_P6_INC = 5'h02, OPAD_M_IND_P7_INC = 5'h03,
    OPAD_M_IND_P6_DEC = 5'h04, OPAD_M_IND_P7_DEC = 5'h05,
    OPAD_M_IND_P4 = 5'h06, OPAD_M_IND_P5 = 5'h07,
    OPAD_M_BASE_P6 = 5'h08, OPAD_M_BASE_P7 = 5'h09, OPAD_M_BASE_SP = 5'h0a,
    OPAD_M_BASE_P5 = 5'h0b, OPAD_M_BASE_P4 = 5'h0c,
    OPAD_M_IDX_A = 5'h0d, OPAD_M_IDX_B = 5'h0e, OPAD_M_IDX_DE = 5'h0f, OPAD_M_IDX_HL = 5'h10,
    OPAD_M_BIX_P6_A = 5'h11, OPAD_M_BIX_P6_B = 5'h12, OPAD_M_BIX_P6_C = 5'h13,
    OPAD_M_BIX_P7_A = 5'h14, OPAD_M_BIX_P7_B = 5'h15, OPAD_M_BIX_P7_C = 5'h16,
    OPAD_M_BIX_P4_DE = 5'h17, OPAD_M_BIX_P4_HL = 5'h18
  } opad_mem_t;

  typedef enum logic [1:0] {
    OPAD_C_IND = 2'h0, OPAD_C_BASED = 2'h1, OPAD_C_INDEXED = 2'h2, OPAD_C_BIX = 2'h3
  } opad_class_t;

  typedef enum logic [1:0] {
    OPAD_X_NONE = 2'h0, OPAD_X_R8 = 2'h1, OPAD_X_RP = 2'h2
  } opad_xkind_t;

  typedef enum logic [2:0] {
    OPAD_W_BIT = 3'h0, OPAD_W_N = 3'h1, OPAD_W_BYTE = 3'h2, OPAD_W_WORD = 3'h3,
    OPAD_W_IMM24 = 3'h4
  } opad_immw_t;

  // Register entries and banking
  localparam logic [3:0] OPAD_R8_A = 4'h1;
  localparam logic [3:0] OPAD_R8_C = 4'h2;
  localparam logic [3:0] OPAD_R8_B = 4'h3;
  localparam logic [3:0] OPAD_R8_BANK = 4'h8;
  localparam logic [3:0] OPAD_R8_FLIP = 4'h4;
  localparam logic [2:0] OPAD_RP_BANK = 3'h4;
  localparam logic [2:0] OPAD_RP_FLIP = 3'h2;
  localparam logic [3:0] OPAD_RP_DE = 4'h6;
  localparam logic [3:0] OPAD_RP_HL = 4'h7;
  localparam logic [4:0] OPAD_RP_MAX = 5'h07;
  localparam logic [4:0] OPAD_RG_MIN = 5'h04;
  localparam logic [4:0] OPAD_RG_MAX = 5'h07;
  localparam logic [2:0] OPAD_B_SP = 3'h0;
  localparam logic [2:0] OPAD_B_P4 = 3'h4;
  localparam logic [2:0] OPAD_B_P5 = 3'h5;
  localparam logic [2:0] OPAD_B_P6 = 3'h6;
  localparam logic [2:0] OPAD_B_P7 = 3'h7;
  localparam int OPAD_PUSH_UP_BIT = 5;

  // Address windows
  localparam logic [15:0] OPAD_SADDR_LO = 16'hfd20;
  localparam logic [15:0] OPAD_SADDR_HI = 16'hff1f;
  localparam logic [15:0] OPAD_SADDRP_HI = 16'hff1e;
  localparam logic [15:0] OPAD_SADDRG_HI = 16'hfefd;
  localparam logic [15:0] OPAD_SADDR1_LO = 16'hfe00;
  localparam logic [15:0] OPAD_SADDR1_HI = 16'hfeff;
  localparam logic [23:0] OPAD_ABS20_MAX = 24'h0fffff;
  localparam logic [23:0] OPAD_ABS16_MAX = 24'h00ffff;
  localparam logic [23:0] OPAD_ADDR11_LO = 24'h000800;
  localparam logic [23:0] OPAD_ADDR11_HI = 24'h000fff;
  localparam logic [23:0] OPAD_ADDR5_LO = 24'h000040;
  localparam logic [23:0] OPAD_ADDR5_HI = 24'h00007e;
  localparam logic [23:0] OPAD_ADDR8_BASE = 24'h00fe00;
  localparam logic [23:0] OPAD_RELOC_OFFSET = 24'h0f0000;
  localparam logic [23:0] OPAD_RELOC_CODE_LOW = 24'h000000;
  localparam logic [23:0] OPAD_RELOC_CODE_HIGH = 24'h00000f;

  // Access and immediate widths in bits
  localparam logic [4:0] OPAD_WID_3 = 5'd3;
  localparam logic [4:0] OPAD_WID_8 = 5'd8;
  localparam logic [4:0] OPAD_WID_16 = 5'd16;
  localparam logic [4:0] OPAD_WID_24 = 5'd24;

  typedef struct packed {
    logic valid;
    opad_kind_t kind;
    logic [4:0] code;
    logic user_stack;
    logic psw_named;
    logic reduced_set;
    logic short_form1;
    opad_immw_t immw;
    logic [23:0] value;
  } opad_req_t;

  typedef struct packed {
    logic valid;
    logic error;
    opad_kind_t kind;
    logic [3:0] entry;
    logic [7:0] push_mask;
    logic psw_sel;
    opad_class_t mem_class;
    logic [2:0] base_sel;
    opad_xkind_t index_kind;
    logic [3:0] index_entry;
    logic post_inc;
    logic post_dec;
    logic [23:0] value;
    logic [4:0] width;
  } opad_res_t;

  typedef struct packed {
    opad_res_t res;
    logic reloc;
  } opad_state_t;

endpackage

// ### core/opad_reg_map.sv
// Register name to register file entry mapping with bank aliasing
`timescale 1ns/100ps
`default_nettype none
module opad_reg_map
  import opad_pkg::*;
(
  input wire logic register_set_select,
  input wire logic [3:0] code,
  output logic [3:0] r8_entry,
  output logic [2:0] rp_entry
);

  // Alias bank swap for the older instruction family
  always_comb begin
    r8_entry = code;
    rp_entry = code[2:0];
    if (register_set_select && code < OPAD_R8_BANK) begin
      r8_entry = code ^ OPAD_R8_FLIP;
    end
    if (register_set_select && code[2:0] < OPAD_RP_BANK && !code[3]) begin
      rp_entry = code[2:0] ^ OPAD_RP_FLIP;
    end
  end

endmodule
`default_nettype wire

// ### core/opad_decoder.sv
// Operand address decoder top module
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Byte register names resolve to entries 0-15
// - Bank select moves X,A,C,B to 4-7
// - Bank select moves AX,BC to pairs 2,3
// - Pair names resolve to pairs 0-7
// - Pointer names select 24-bit entries 4-7
// - UP system stack only, status word user only
// - Indirect, based, indexed, based-indexed memory forms
// - Reduced set forbids pointer seven auto step
// - Short direct byte window with two encodings
// - Multi-byte short direct stays inside window
// - Absolute ranges for 24/20 and 16 bits
// - Eleven-bit address limited 800H to FFFH
// - Five-bit address limited 40H to 7EH
// - Relocation takes only 00H or 0FH
// - Relocated windows gain F0000H offset
// - Immediate widths 3, 3, 8, 16, 24 bits
module opad_decoder
  import opad_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic register_set_select,
  input wire opad_req_t req,
  output opad_res_t res,
  output logic window_relocated
);

  opad_state_t st;
  opad_state_t next_st;
  logic [3:0] map_code;
  logic [3:0] r8_entry;
  logic [2:0] rp_entry;
  logic [15:0] saddr;
  logic [15:0] saddr_hi;
  logic [15:0] saddr1_hi;
  logic saddr_in_win;
  logic saddr_in_f1;
  logic [23:0] win_offset;

  // Pick the name that the shared mapper resolves
  always_comb begin
    map_code = req.code[3:0];
    if (req.kind == OPAD_K_MEM) begin
      unique case (req.code)
        OPAD_M_IDX_A, OPAD_M_BIX_P6_A, OPAD_M_BIX_P7_A: map_code = OPAD_R8_A;
        OPAD_M_IDX_B, OPAD_M_BIX_P6_B, OPAD_M_BIX_P7_B: map_code = OPAD_R8_B;
        OPAD_M_BIX_P6_C, OPAD_M_BIX_P7_C: map_code = OPAD_R8_C;
        OPAD_M_IDX_DE, OPAD_M_BIX_P4_DE: map_code = OPAD_RP_DE;
        OPAD_M_IDX_HL, OPAD_M_BIX_P4_HL: map_code = OPAD_RP_HL;
        default: map_code = req.code[3:0];
      endcase
    end
  end

  opad_reg_map u_map (
    .register_set_select(register_set_select),
    .code(map_code),
    .r8_entry(r8_entry),
    .rp_entry(rp_entry)
  );

  // Short direct window limits per access width
  always_comb begin
    saddr = req.value[15:0];
    saddr_hi = OPAD_SADDR_HI;
    saddr1_hi = OPAD_SADDR1_HI;
    if (req.kind == OPAD_K_SADDR16) begin
      saddr_hi = OPAD_SADDRP_HI;
    end else if (req.kind == OPAD_K_SADDR24) begin
      saddr_hi = OPAD_SADDRG_HI;
      saddr1_hi = OPAD_SADDRG_HI;
    end
    saddr_in_win = (req.value[23:16] == 8'h00) && saddr >= OPAD_SADDR_LO && saddr <= saddr_hi;
    saddr_in_f1 = saddr >= OPAD_SADDR1_LO && saddr <= saddr1_hi;
    win_offset = st.reloc ? OPAD_RELOC_OFFSET : 24'h000000;
  end

  // Main decode of one operand per cycle
  always_comb begin
    next_st = st;
    next_st.res = '0;
    next_st.res.valid = req.valid;
    next_st.res.kind = req.kind;
    if (req.valid) begin
      unique case (req.kind)
        OPAD_K_REG8: begin
          next_st.res.entry = r8_entry;
          next_st.res.error = req.code[4];
          next_st.res.width = OPAD_WID_8;
        end
        OPAD_K_REG16: begin
          next_st.res.entry = {1'b0, rp_entry};
          next_st.res.error = req.code > OPAD_RP_MAX;
          next_st.res.width = OPAD_WID_16;
        end
        OPAD_K_REG24: begin
          next_st.res.entry = req.code[3:0];
          next_st.res.error = req.code < OPAD_RG_MIN || req.code > OPAD_RG_MAX;
          next_st.res.width = OPAD_WID_24;
        end
        OPAD_K_PUSH: begin
          next_st.res.push_mask = req.value[7:0];
          next_st.res.psw_sel = req.psw_named;
          // Slot five is the status word on the user stack only
          next_st.res.error = req.value[OPAD_PUSH_UP_BIT] &&
                              (req.psw_named != req.user_stack);
          next_st.res.width = OPAD_WID_16;
        end
        OPAD_K_MEM: begin
          next_st.res.width = OPAD_WID_24;
          next_st.res.index_entry = r8_entry;
          unique case (req.code)
            OPAD_M_IND_P6, OPAD_M_IND_P6_INC, OPAD_M_IND_P6_DEC: begin
              next_st.res.mem_class = OPAD_C_IND;
              next_st.res.base_sel = OPAD_B_P6;
              next_st.res.post_inc = req.code == OPAD_M_IND_P6_INC;
              next_st.res.post_dec = req.code == OPAD_M_IND_P6_DEC;
            end
            OPAD_M_IND_P7, OPAD_M_IND_P7_INC, OPAD_M_IND_P7_DEC: begin
              next_st.res.mem_class = OPAD_C_IND;
              next_st.res.base_sel = OPAD_B_P7;
              next_st.res.post_inc = req.code == OPAD_M_IND_P7_INC;
              next_st.res.post_dec = req.code == OPAD_M_IND_P7_DEC;
              next_st.res.error = req.reduced_set && req.code != OPAD_M_IND_P7;
            end
            OPAD_M_IND_P4, OPAD_M_IND_P5: begin
              next_st.res.mem_class = OPAD_C_IND;
              next_st.res.base_sel = req.code == OPAD_M_IND_P4 ? OPAD_B_P4 : OPAD_B_P5;
            end
            OPAD_M_BASE_P6, OPAD_M_BASE_P7, OPAD_M_BASE_SP, OPAD_M_BASE_P5,
            OPAD_M_BASE_P4: begin
              next_st.res.mem_class = OPAD_C_BASED;
              next_st.res.value = {16'h0000, req.value[7:0]};
              unique case (req.code)
                OPAD_M_BASE_P6: next_st.res.base_sel = OPAD_B_P6;
                OPAD_M_BASE_P7: next_st.res.base_sel = OPAD_B_P7;
                OPAD_M_BASE_P5: next_st.res.base_sel = OPAD_B_P5;
                OPAD_M_BASE_P4: next_st.res.base_sel = OPAD_B_P4;
                default: next_st.res.base_sel = OPAD_B_SP;
              endcase
            end
            OPAD_M_IDX_A, OPAD_M_IDX_B: begin
              next_st.res.mem_class = OPAD_C_INDEXED;
              next_st.res.index_kind = OPAD_X_R8;
              next_st.res.value = req.value;
            end
            OPAD_M_IDX_DE, OPAD_M_IDX_HL: begin
              next_st.res.mem_class = OPAD_C_INDEXED;
              next_st.res.index_kind = OPAD_X_RP;
              next_st.res.index_entry = {1'b0, rp_entry};
              next_st.res.value = req.value;
            end
            OPAD_M_BIX_P6_A, OPAD_M_BIX_P6_B, OPAD_M_BIX_P6_C,
            OPAD_M_BIX_P7_A, OPAD_M_BIX_P7_B, OPAD_M_BIX_P7_C: begin
              next_st.res.mem_class = OPAD_C_BIX;
              next_st.res.index_kind = OPAD_X_R8;
              next_st.res.base_sel = req.code < OPAD_M_BIX_P7_A ? OPAD_B_P6 : OPAD_B_P7;
            end
            OPAD_M_BIX_P4_DE, OPAD_M_BIX_P4_HL: begin
              next_st.res.mem_class = OPAD_C_BIX;
              next_st.res.index_kind = OPAD_X_RP;
              next_st.res.index_entry = {1'b0, rp_entry};
              next_st.res.base_sel = OPAD_B_P4;
            end
            default: next_st.res.error = 1'b1;
          endcase
        end
        OPAD_K_SADDR8, OPAD_K_SADDR16, OPAD_K_SADDR24: begin
          // Encoding form must match the sub-window it names
          next_st.res.error = !saddr_in_win || (req.short_form1 != saddr_in_f1);
          next_st.res.value = {8'h00, saddr} + win_offset;
          unique case (req.kind)
            OPAD_K_SADDR8: next_st.res.width = OPAD_WID_8;
            OPAD_K_SADDR16: next_st.res.width = OPAD_WID_16;
            default: next_st.res.width = OPAD_WID_24;
          endcase
        end
        OPAD_K_ABS24, OPAD_K_ABS20: begin
          next_st.res.error = req.value > OPAD_ABS20_MAX;
          next_st.res.value = req.value;
          next_st.res.width = OPAD_WID_24;
        end
        OPAD_K_ABS16: begin
          next_st.res.error = req.value > OPAD_ABS16_MAX;
          next_st.res.value = req.value;
          next_st.res.width = OPAD_WID_16;
        end
        OPAD_K_ADDR11: begin
          next_st.res.error = req.value < OPAD_ADDR11_LO || req.value > OPAD_ADDR11_HI;
          next_st.res.value = req.value;
          next_st.res.width = OPAD_WID_16;
        end
        OPAD_K_ADDR8: begin
          next_st.res.value = (OPAD_ADDR8_BASE | {16'h0000, req.value[7:0]}) + win_offset;
          next_st.res.error = req.value[23:8] != 16'h0000;
          next_st.res.width = OPAD_WID_8;
        end
        OPAD_K_ADDR5: begin
          next_st.res.error = req.value < OPAD_ADDR5_LO || req.value > OPAD_ADDR5_HI;
          next_st.res.value = req.value;
          next_st.res.width = OPAD_WID_16;
        end
        OPAD_K_RELOC: begin
          next_st.res.value = req.value;
          if (req.value == OPAD_RELOC_CODE_LOW || req.value == OPAD_RELOC_CODE_HIGH) begin
            next_st.reloc = req.value == OPAD_RELOC_CODE_HIGH;
          end else begin
            next_st.res.error = 1'b1;
          end
        end
        OPAD_K_IMM: begin
          // Immediates are cut to the width of their operand class
          unique case (req.immw)
            OPAD_W_BIT, OPAD_W_N: begin
              next_st.res.value = {21'h000000, req.value[2:0]};
              next_st.res.width = OPAD_WID_3;
            end
            OPAD_W_BYTE: begin
              next_st.res.value = {16'h0000, req.value[7:0]};
              next_st.res.width = OPAD_WID_8;
            end
            OPAD_W_WORD: begin
              next_st.res.value = {8'h00, req.value[15:0]};
              next_st.res.width = OPAD_WID_16;
            end
            OPAD_W_IMM24: begin
              next_st.res.value = req.value;
              next_st.res.width = OPAD_WID_24;
            end
            default: next_st.res.error = 1'b1;
          endcase
        end
        default: next_st.res.error = 1'b1;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  assign res = st.res;
  assign window_relocated = st.reloc;

  // Checks on the decoded result, one cycle after the request
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence seq_reloc_high;
    req.valid && req.kind == OPAD_K_RELOC && req.value == OPAD_RELOC_CODE_HIGH;
  endsequence

  sequence seq_reloc_low;
    req.valid && req.kind == OPAD_K_RELOC && req.value == OPAD_RELOC_CODE_LOW;
  endsequence

  sequence seq_short_byte;
    req.valid && req.kind == OPAD_K_SADDR8;
  endsequence

  reg8_plain_a: assert property (
    req.valid && req.kind == OPAD_K_REG8 && !register_set_select && !req.code[4]
    |=> res.valid && !res.error && res.entry == $past(req.code[3:0]))
    else $error("byte register entry wrong");

  reg8_bank_a: assert property (
    req.valid && req.kind == OPAD_K_REG8 && register_set_select && req.code < 5'h04
    |=> res.entry == $past(req.code[3:0]) + 4'h4)
    else $error("banked byte register entry wrong");

  pair_bank_a: assert property (
    req.valid && req.kind == OPAD_K_REG16 && register_set_select && req.code < 5'h02
    |=> !res.error && res.entry == $past(req.code[3:0]) + 4'h2)
    else $error("banked pair entry wrong");

  pair_range_a: assert property (
    req.valid && req.kind == OPAD_K_REG16 |=> res.error == ($past(req.code) > 5'h07))
    else $error("pair range check wrong");

  ptr24_range_a: assert property (
    req.valid && req.kind == OPAD_K_REG24
    |=> res.error == ($past(req.code) < 5'h04 || $past(req.code) > 5'h07))
    else $error("pointer register range wrong");

  push_slot_a: assert property (
    req.valid && req.kind == OPAD_K_PUSH && req.value[5] && req.psw_named && !req.user_stack
    |=> res.error && res.psw_sel)
    else $error("status word accepted on system stack");

  step_form_a: assert property (
    req.valid && req.kind == OPAD_K_MEM && req.code == OPAD_M_IND_P6_INC
    |=> res.post_inc && !res.post_dec && res.base_sel == OPAD_B_P6 && !res.error)
    else $error("post increment form wrong");

  reduced_set_a: assert property (
    req.valid && req.kind == OPAD_K_MEM && req.reduced_set &&
    (req.code == OPAD_M_IND_P7_INC || req.code == OPAD_M_IND_P7_DEC)
    |=> res.error)
    else $error("reduced set accepted auto step");

  short_window_a: assert property (
    seq_short_byte ##0 (req.value[15:0] < OPAD_SADDR_LO || req.value[15:0] > OPAD_SADDR_HI)
    |=> res.error)
    else $error("short byte outside window accepted");

  short_pair_a: assert property (
    req.valid && req.kind == OPAD_K_SADDR16 && req.value == 24'h00ff1f |=> res.error)
    else $error("short pair past window accepted");

  abs16_range_a: assert property (
    req.valid && req.kind == OPAD_K_ABS16 |=> res.error == ($past(req.value) > 24'h00ffff))
    else $error("16-bit absolute range wrong");

  addr11_range_a: assert property (
    req.valid && req.kind == OPAD_K_ADDR11 && req.value == 24'h0007ff |=> res.error)
    else $error("11-bit address below range accepted");

  addr5_range_a: assert property (
    req.valid && req.kind == OPAD_K_ADDR5 && req.value == 24'h00007f |=> res.error)
    else $error("5-bit address above range accepted");

  reloc_code_a: assert property (
    req.valid && req.kind == OPAD_K_RELOC && req.value != 24'h000000 &&
    req.value != 24'h00000f |=> res.error && $stable(window_relocated))
    else $error("bad relocation code accepted");

  reloc_low_a: assert property (
    seq_reloc_low ##1 (seq_short_byte ##0 req.value[15:0] == 16'hfe10)
    |=> res.value == 24'h00fe10 && !window_relocated)
    else $error("unrelocated window address wrong");

  reloc_add_a: assert property (
    seq_reloc_high ##1 (seq_short_byte ##0 req.value[15:0] == 16'hfe10)
    |=> res.value == 24'h0ffe10 && window_relocated)
    else $error("relocated window address wrong");

  imm_bit_a: assert property (
    req.valid && req.kind == OPAD_K_IMM && req.immw == OPAD_W_BIT
    |=> res.width == 5'd3 && res.value[23:3] == 21'h000000)
    else $error("bit immediate width wrong");

endmodule
`default_nettype wire

// ### verif/tb_operand_address_decode.sv
// Self-checking testbench for the operand address decoder
`timescale 1ns/100ps
`default_nettype none
module tb_operand_address_decode
  import opad_pkg::*;
;
  // Table row: kind, code, flags {bank,user,status,reduced,form1}, value, error, field, expect
  typedef struct packed {
    opad_kind_t k;
    logic [4:0] c;
    logic [4:0] f;
    logic [23:0] v;
    logic e;
    logic [1:0] sel;
    logic [23:0] x;
  } opad_row_t;

  logic clock = 1'b0;
  logic rst = 1'b1;
  logic register_set_select = 1'b0;
  opad_req_t req = '0;
  opad_res_t res;
  logic window_relocated;
  int n_fail = 0;
  int checks = 0;

  // Ordinary cases, field 1 value, 2 width, 3 entry
  opad_row_t rows [] = '{
    '{OPAD_K_REG8, 5'h01, 5'h00, 24'h0, 1'b0, 2'h3, 24'h1},
    '{OPAD_K_REG8, 5'h0f, 5'h00, 24'h0, 1'b0, 2'h3, 24'hf},
    '{OPAD_K_REG8, 5'h10, 5'h00, 24'h0, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_REG8, 5'h01, 5'h10, 24'h0, 1'b0, 2'h3, 24'h5},
    '{OPAD_K_REG8, 5'h07, 5'h10, 24'h0, 1'b0, 2'h3, 24'h3},
    '{OPAD_K_REG16, 5'h00, 5'h10, 24'h0, 1'b0, 2'h3, 24'h2},
    '{OPAD_K_REG16, 5'h03, 5'h10, 24'h0, 1'b0, 2'h3, 24'h1},
    '{OPAD_K_REG16, 5'h07, 5'h00, 24'h0, 1'b0, 2'h3, 24'h7},
    '{OPAD_K_REG24, 5'h06, 5'h00, 24'h0, 1'b0, 2'h3, 24'h6},
    '{OPAD_K_REG24, 5'h03, 5'h00, 24'h0, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_PUSH, 5'h00, 5'h00, 24'h20, 1'b0, 2'h0, 24'h0},
    '{OPAD_K_PUSH, 5'h00, 5'h04, 24'h20, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_PUSH, 5'h00, 5'h0c, 24'h20, 1'b0, 2'h0, 24'h0},
    '{OPAD_K_PUSH, 5'h00, 5'h08, 24'h20, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_MEM, 5'h03, 5'h02, 24'h0, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_MEM, 5'h05, 5'h02, 24'h0, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_MEM, 5'h02, 5'h02, 24'h0, 1'b0, 2'h0, 24'h0},
    '{OPAD_K_MEM, 5'h03, 5'h00, 24'h0, 1'b0, 2'h0, 24'h0},
    '{OPAD_K_MEM, 5'h18, 5'h00, 24'h0, 1'b0, 2'h0, 24'h0},
    '{OPAD_K_MEM, 5'h19, 5'h00, 24'h0, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_MEM, 5'h09, 5'h00, 24'hab, 1'b0, 2'h1, 24'hab},
    '{OPAD_K_SADDR8, 5'h0, 5'h01, 24'hfe10, 1'b0, 2'h1, 24'hfe10},
    '{OPAD_K_SADDR8, 5'h0, 5'h01, 24'hfe10, 1'b0, 2'h2, 24'h8},
    '{OPAD_K_SADDR8, 5'h0, 5'h00, 24'hfe10, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_SADDR8, 5'h0, 5'h00, 24'hfd20, 1'b0, 2'h0, 24'h0},
    '{OPAD_K_SADDR8, 5'h0, 5'h00, 24'hfd1f, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_SADDR8, 5'h0, 5'h00, 24'hff1f, 1'b0, 2'h0, 24'h0},
    '{OPAD_K_SADDR8, 5'h0, 5'h00, 24'hff20, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_SADDR16, 5'h0, 5'h00, 24'hff1e, 1'b0, 2'h0, 24'h0},
    '{OPAD_K_SADDR16, 5'h0, 5'h00, 24'hff1f, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_SADDR24, 5'h0, 5'h01, 24'hfefd, 1'b0, 2'h0, 24'h0},
    '{OPAD_K_SADDR24, 5'h0, 5'h01, 24'hfefe, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_ABS24, 5'h0, 5'h00, 24'hfffff, 1'b0, 2'h0, 24'h0},
    '{OPAD_K_ABS20, 5'h0, 5'h00, 24'h100000, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_ABS16, 5'h0, 5'h00, 24'hffff, 1'b0, 2'h0, 24'h0},
    '{OPAD_K_ABS16, 5'h0, 5'h00, 24'h10000, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_ADDR11, 5'h0, 5'h00, 24'h800, 1'b0, 2'h0, 24'h0},
    '{OPAD_K_ADDR11, 5'h0, 5'h00, 24'h7ff, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_ADDR11, 5'h0, 5'h00, 24'hfff, 1'b0, 2'h0, 24'h0},
    '{OPAD_K_ADDR11, 5'h0, 5'h00, 24'h1000, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_ADDR5, 5'h0, 5'h00, 24'h40, 1'b0, 2'h0, 24'h0},
    '{OPAD_K_ADDR5, 5'h0, 5'h00, 24'h3f, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_ADDR5, 5'h0, 5'h00, 24'h7e, 1'b0, 2'h0, 24'h0},
    '{OPAD_K_ADDR5, 5'h0, 5'h00, 24'h7f, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_ADDR8, 5'h0, 5'h00, 24'h10, 1'b0, 2'h1, 24'hfe10},
    '{OPAD_K_RELOC, 5'h0, 5'h00, 24'h05, 1'b1, 2'h0, 24'h0},
    '{OPAD_K_IMM, 5'h0, 5'h00, 24'h0, 1'b0, 2'h2, 24'h3},
    '{OPAD_K_IMM, 5'h1, 5'h00, 24'h0, 1'b0, 2'h2, 24'h3},
    '{OPAD_K_IMM, 5'h2, 5'h00, 24'h0, 1'b0, 2'h2, 24'h8},
    '{OPAD_K_IMM, 5'h3, 5'h00, 24'h0, 1'b0, 2'h2, 24'h10},
    '{OPAD_K_IMM, 5'h4, 5'h00, 24'h0, 1'b0, 2'h2, 24'h18},
    '{OPAD_K_IMM, 5'h5, 5'h00, 24'h0, 1'b1, 2'h0, 24'h0}
  };

  // Clock at 125 MHz
  always #4 clock = ~clock;

  opad_decoder dut (
    .clock(clock),
    .rst(rst),
    .register_set_select(register_set_select),
    .req(req),
    .res(res),
    .window_relocated(window_relocated)
  );

  // Request built from a row; the code also carries the immediate width code
  function automatic opad_req_t mkreq(input opad_row_t r);
    return '{valid: 1'b1, kind: r.k, code: r.c, user_stack: r.f[3], psw_named: r.f[2],
      reduced_set: r.f[1], short_form1: r.f[0], immw: opad_immw_t'(r.c[2:0]), value: r.v};
  endfunction

  task automatic chk_flag(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_field(input logic [23:0] got, input logic [23:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One request, then idle; the result is looked at in the cycle after it is taken
  task automatic send(input opad_row_t r);
    @(posedge clock);
    register_set_select <= r.f[4];
    req <= mkreq(r);
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 150 cycles
  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk_flag(res.valid, 1'b0, "valid after reset");
    chk_flag(window_relocated, 1'b0, "relocated after reset");
    $display("reset test done");
    foreach (rows[i]) begin
      send(rows[i]);
      chk_flag(res.valid, 1'b1, "valid");
      chk_flag(res.error, rows[i].e, "error");
      chk_field({19'h0, res.kind}, {19'h0, rows[i].k}, "kind");
      case (rows[i].sel)
        2'h1: chk_field(res.value, rows[i].x, "value");
        2'h2: chk_field({19'h0, res.width}, rows[i].x, "width");
        2'h3: chk_field({20'h0, res.entry}, rows[i].x, "entry");
        default: ;
      endcase
    end
    chk_flag(window_relocated, 1'b0, "refused relocation kept");
    $display("row table done");
    // Memory form fields: class, index kind and entry, base, steps, push list
    send('{OPAD_K_MEM, 5'h0d, 5'h10, 24'h0, 1'b0, 2'h0, 24'h0});
    chk_field({16'h0, res.mem_class, res.index_kind, res.index_entry}, 24'h000095, "idx A");
    send('{OPAD_K_MEM, 5'h17, 5'h00, 24'h0, 1'b0, 2'h0, 24'h0});
    chk_field({13'h0, res.base_sel, res.mem_class, res.index_kind, res.index_entry},
      24'h0004e6, "based indexed DE");
    send('{OPAD_K_MEM, 5'h04, 5'h00, 24'h0, 1'b0, 2'h0, 24'h0});
    chk_field({18'h0, res.post_inc, res.post_dec, 1'b0, res.base_sel}, 24'h000016, "step");
    send('{OPAD_K_PUSH, 5'h00, 5'h0c, 24'h21, 1'b0, 2'h0, 24'h0});
    chk_field({15'h0, res.psw_sel, res.push_mask}, 24'h000121, "push list");
    $display("memory form test done");
    // Relocation back to back with a short direct access
    @(posedge clock);
    req <= mkreq('{OPAD_K_RELOC, 5'h0, 5'h00, 24'h0f, 1'b0, 2'h0, 24'h0});
    @(posedge clock);
    req <= mkreq('{OPAD_K_SADDR8, 5'h0, 5'h01, 24'hfe10, 1'b0, 2'h0, 24'h0});
    #1;
    chk_flag(window_relocated, 1'b1, "relocated");
    @(posedge clock);
    req <= mkreq('{OPAD_K_ADDR8, 5'h0, 5'h00, 24'h10, 1'b0, 2'h0, 24'h0});
    #1;
    chk_field(res.value, 24'h0ffe10, "relocated short direct");
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
    chk_field(res.value, 24'h0ffe10, "relocated byte address");
    @(posedge clock);
    #1;
    chk_flag(res.valid, 1'b0, "idle valid");
    send('{OPAD_K_RELOC, 5'h0, 5'h00, 24'h05, 1'b0, 2'h0, 24'h0});
    chk_flag(window_relocated, 1'b1, "refused relocation");
    send('{OPAD_K_RELOC, 5'h0, 5'h00, 24'h00, 1'b0, 2'h0, 24'h0});
    chk_flag(window_relocated, 1'b0, "relocation undone");
    // Back to back: code 00 then a short direct access stays unrelocated
    @(posedge clock);
    req <= mkreq('{OPAD_K_RELOC, 5'h0, 5'h00, 24'h00, 1'b0, 2'h0, 24'h0});
    @(posedge clock);
    req <= mkreq('{OPAD_K_SADDR8, 5'h0, 5'h01, 24'hfe10, 1'b0, 2'h0, 24'h0});
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
    chk_field(res.value, 24'h00fe10, "unrelocated short direct");
    $display("relocation test done");
    // Second reset in mid-run clears the relocation
    send('{OPAD_K_RELOC, 5'h0, 5'h00, 24'h0f, 1'b0, 2'h0, 24'h0});
    @(posedge clock);
    rst <= 1'b1;
    #1;
    chk_flag(window_relocated, 1'b0, "relocated in reset");
    @(posedge clock);
    rst <= 1'b0;
    send('{OPAD_K_SADDR8, 5'h0, 5'h01, 24'hfe10, 1'b0, 2'h0, 24'h0});
    chk_field(res.value, 24'h00fe10, "value after reset");
    $display("second reset test done");
    test_done();
  end
endmodule
`default_nettype wire
